// ==== core/lmec_map.svh ====
// Constants for the limit monitor and event counter block.
// Notes on behaviour
// - three monitors, each enabled and variable-selectable
// - selectable variables are the active ones only
// - severity picks warning or warning plus interrupt
// - direction picks upper, lower or both
// - thresholds compared directly in variable units
// - hysteresis band suppresses violation chatter
// - violation registers only after response time
// - warning held for at least stop time
// - optional counters tally upper and lower separately
// - each counter warns at its comparison count
// - per counter severity: warning or plus interrupt
// - host resets counters; one event per interval
// - clearing a counter restarts accumulation at zero
// - separate acknowledge per message, no collective clear
`ifndef LMEC_MAP_SVH
`define LMEC_MAP_SVH

`define LMEC_NMON      3
`define LMEC_NVAR      4
`define LMEC_SELW      2
`define LMEC_VW        16
`define LMEC_TW        16
`define LMEC_CW        16

`define LMEC_SIDE_UP   0
`define LMEC_SIDE_LO   1

`define LMEC_TICK_US   1000
`define LMEC_CLK_MHZ   125
`define LMEC_TICK_CYC  (`LMEC_TICK_US * `LMEC_CLK_MHZ)

`define LMEC_RST_VAL   16'h0000
`define LMEC_RST_BIT   1'h0

`endif

// ==== core/lmec_pkg.sv ====
// Types shared by the limit monitor and event counter modules.
package lmec_pkg;

	typedef enum logic [1:0] {
		LMEC_DIR_OFF  = 2'b00,
		LMEC_DIR_UP   = 2'b01,
		LMEC_DIR_LO   = 2'b10,
		LMEC_DIR_BOTH = 2'b11
	} lmec_dir_t;

	typedef enum logic {
		LMEC_SEV_WARN = 1'b0,
		LMEC_SEV_IRQ  = 1'b1
	} lmec_sev_t;

endpackage

// ==== core/lmec_cnt_if.sv ====
// Interface between the monitor logic and one event counter.
`timescale 1ns/100ps
`include "lmec_map.svh"

interface lmec_cnt_if;
	logic                   en;
	logic                   evt;
	logic                   clr;
	logic                   ack;
	logic [`LMEC_CW-1:0]    cmp;
	logic [`LMEC_CW-1:0]    count;
	logic                   warn;

	modport cnt (
		input  en,
		input  evt,
		input  clr,
		input  ack,
		input  cmp,
		output count,
		output warn
	);

	modport ctl (
		output en,
		output evt,
		output clr,
		output ack,
		output cmp,
		input  count,
		input  warn
	);
endinterface // lmec_cnt_if

// ==== core/lmec_counter.sv ====
// One cumulative violation counter with its comparison warning.
`timescale 1ns/100ps
`include "lmec_map.svh"

module lmec_counter (
	input  wire logic   clk,
	input  wire logic   nrst,
	lmec_cnt_if.cnt     port
);

	logic [`LMEC_CW-1:0]    count;
	logic                   fired;
	logic                   warn;
	wire                    at_max;
	wire                    bump;
	wire  [`LMEC_CW-1:0]    next_count;
	wire                    fire;

	assign at_max     = &count;
	assign bump       = port.en & port.evt & ~at_max;
	assign next_count = port.clr ? `LMEC_RST_VAL :
	                    bump     ? count + `LMEC_CW'(1) : count;
	// A comparison count of zero never fires, so a blank setting stays quiet.
	assign fire       = ~port.clr & ~fired & (port.cmp != `LMEC_RST_VAL) & (next_count >= port.cmp);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			count <= `LMEC_RST_VAL;
			fired <= `LMEC_RST_BIT;
			warn  <= `LMEC_RST_BIT;
		end else begin
			count <= next_count;
			fired <= port.clr ? 1'h0 : (fired | fire);
			warn  <= fire | (warn & ~port.ack);
		end
	end

	assign port.count = count;
	assign port.warn  = warn;

endmodule // lmec_counter

// ==== core/lmec_top.sv ====
// Three limit monitors with hysteresis, response and stop timers, and event counters.
`timescale 1ns/100ps
`include "lmec_map.svh"

module lmec_top #(
	parameter int unsigned TICK_CYCLES = `LMEC_TICK_CYC
) (
	input  wire logic                                      clk,
	input  wire logic                                      nrst,
	input  wire logic [`LMEC_NVAR-1:0][`LMEC_VW-1:0]       var_value,
	input  wire logic [`LMEC_NVAR-1:0]                     var_active,
	input  wire logic [`LMEC_NMON-1:0]                     mon_enable,
	input  wire logic [`LMEC_NMON-1:0][`LMEC_SELW-1:0]     mon_sel,
	input  wire logic [`LMEC_NMON-1:0]                     mon_sev,
	input  wire logic [`LMEC_NMON-1:0][1:0]                mon_dir,
	input  wire logic [`LMEC_NMON-1:0][`LMEC_VW-1:0]       mon_upper,
	input  wire logic [`LMEC_NMON-1:0][`LMEC_VW-1:0]       mon_lower,
	input  wire logic [`LMEC_NMON-1:0][`LMEC_VW-1:0]       mon_hyst,
	input  wire logic [`LMEC_NMON-1:0][`LMEC_TW-1:0]       mon_resp,
	input  wire logic [`LMEC_NMON-1:0][`LMEC_TW-1:0]       mon_stop,
	input  wire logic [`LMEC_NMON-1:0]                     lim_ack,
	input  wire logic [`LMEC_NMON-1:0]                     cnt_enable,
	input  wire logic [`LMEC_NMON-1:0][1:0]                cnt_sev,
	input  wire logic [`LMEC_NMON-1:0][1:0][`LMEC_CW-1:0]  cnt_cmp,
	input  wire logic [`LMEC_NMON-1:0][1:0]                cnt_clr,
	input  wire logic [`LMEC_NMON-1:0][1:0]                cnt_ack,
	output logic      [`LMEC_NMON-1:0]                     lim_warn,
	output logic      [`LMEC_NMON-1:0]                     lim_irq,
	output logic      [`LMEC_NMON-1:0]                     lim_unack,
	output logic      [`LMEC_NMON-1:0][1:0]                lim_viol,
	output logic      [`LMEC_NMON-1:0][1:0][`LMEC_CW-1:0]  cnt_value,
	output logic      [`LMEC_NMON-1:0][1:0]                cnt_warn,
	output logic      [`LMEC_NMON-1:0][1:0]                cnt_irq
);

	// True when the programmed direction covers the given side.
	function automatic logic lmec_dir_has(input logic [1:0] dir, input logic side);
		lmec_pkg::lmec_dir_t d;
		d = lmec_pkg::lmec_dir_t'(dir);
		if (side == 1'h0) begin
			lmec_dir_has = (d == lmec_pkg::LMEC_DIR_UP) || (d == lmec_pkg::LMEC_DIR_BOTH);
		end else begin
			lmec_dir_has = (d == lmec_pkg::LMEC_DIR_LO) || (d == lmec_pkg::LMEC_DIR_BOTH);
		end
	endfunction

	// True when a severity setting asks for an interrupt as well as the warning.
	function automatic logic lmec_sev_irq(input logic sev);
		lmec_sev_irq = (lmec_pkg::lmec_sev_t'(sev) == lmec_pkg::LMEC_SEV_IRQ);
	endfunction

	localparam int unsigned TICK_LAST = (TICK_CYCLES > 1) ? TICK_CYCLES - 1 : 0;

	logic [31:0]                                    tick_cnt;
	logic                                           tick;
	wire                                            tick_wrap;

	wire  [`LMEC_NMON-1:0]                          next_lim_warn;
	wire  [`LMEC_NMON-1:0]                          next_lim_irq;
	wire  [`LMEC_NMON-1:0]                          next_lim_unack;
	wire  [`LMEC_NMON-1:0][1:0]                     next_lim_viol;
	wire  [`LMEC_NMON-1:0][1:0][`LMEC_CW-1:0]       next_cnt_value;
	wire  [`LMEC_NMON-1:0][1:0]                     next_cnt_warn;
	wire  [`LMEC_NMON-1:0][1:0]                     next_cnt_irq;

	// Timebase shared by every response and stop timer.
	assign tick_wrap = (tick_cnt >= TICK_LAST);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tick_cnt <= 32'h00000000;
			tick     <= 1'h0;
		end else begin
			tick_cnt <= tick_wrap ? 32'h00000000 : tick_cnt + 32'h00000001;
			tick     <= tick_wrap;
		end
	end

	genvar i;
	genvar j;
	generate
		for (i = 0; i < `LMEC_NMON; i++) begin : g_mon
			wire [`LMEC_VW-1:0]   sel_val;
			wire                  sel_ok;
			wire [1:0]            rise;
			wire [1:0]            lvl;
			logic                 hold;
			logic [`LMEC_TW-1:0]  scnt;
			logic                 unack;
			wire                  any_rise;
			wire                  stop_done;
			wire                  lim_active;

			// An inactive variable is not on offer, so selecting it watches nothing.
			assign sel_val = var_value[mon_sel[i]];
			assign sel_ok  = mon_enable[i] & var_active[mon_sel[i]];

			for (j = 0; j < 2; j++) begin : g_side
				wire signed [`LMEC_VW+1:0] val;
				wire signed [`LMEC_VW+1:0] thr;
				wire signed [`LMEC_VW+1:0] hys;
				wire signed [`LMEC_VW+1:0] rel_thr;
				wire                       watch;
				wire                       trip;
				wire                       release_ok;
				wire                       next_cond;
				wire                       next_lvl;
				logic                      cond;
				logic                      lvl_q;
				logic [`LMEC_TW-1:0]       rcnt;

				assign val   = (`LMEC_VW+2)'($signed(sel_val));
				assign thr   = (j == `LMEC_SIDE_UP) ? (`LMEC_VW+2)'($signed(mon_upper[i]))
				                                    : (`LMEC_VW+2)'($signed(mon_lower[i]));
				// The band is unsigned, so it gets a zero on top before the sign extension.
				assign hys   = (`LMEC_VW+2)'($signed({1'h0, mon_hyst[i]}));
				assign watch = sel_ok & lmec_dir_has(mon_dir[i], 1'(j));
				// The wider width keeps threshold plus band from wrapping near the range ends.
				assign rel_thr    = (j == `LMEC_SIDE_UP) ? thr - hys : thr + hys;
				// Trip compares are strict, so a value equal to a threshold never trips.
				assign trip       = (j == `LMEC_SIDE_UP) ? (val > thr) : (val < thr);
				assign release_ok = (j == `LMEC_SIDE_UP) ? (val < rel_thr) : (val > rel_thr);
				assign next_cond  = watch & (trip | (cond & ~release_ok));
				assign next_lvl   = cond & (lvl_q | (rcnt >= mon_resp[i]));

				always_ff @(posedge clk or negedge nrst) begin
					if (!nrst) begin
						cond  <= 1'h0;
						lvl_q <= 1'h0;
						rcnt  <= `LMEC_RST_VAL;
					end else begin
						cond  <= next_cond;
						lvl_q <= next_lvl & next_cond;
						// The tick runs free, so a response of N ticks lasts between N-1 and N tick periods.
						// The count stops at its target, so a long violation never wraps it back below.
						if (!cond) begin
							rcnt <= `LMEC_RST_VAL;
						end else if (tick && (rcnt < mon_resp[i])) begin
							rcnt <= rcnt + `LMEC_TW'(1);
						end
					end
				end

				assign lvl[j]  = lvl_q;
				assign rise[j] = next_lvl & next_cond & ~lvl_q;

				// The counter sees only the rising edge of a registered violation, one event per episode.
				lmec_cnt_if cif ();
				assign cif.en  = cnt_enable[i];
				assign cif.evt = rise[j];
				assign cif.clr = cnt_clr[i][j];
				assign cif.ack = cnt_ack[i][j];
				assign cif.cmp = cnt_cmp[i][j];

				lmec_counter u_cnt (
					.clk  (clk),
					.nrst (nrst),
					.port (cif.cnt)
				);

				assign next_lim_viol[i][j]  = lvl_q;
				assign next_cnt_value[i][j] = cif.count;
				assign next_cnt_warn[i][j]  = cif.warn;
				assign next_cnt_irq[i][j]   = cif.warn & lmec_sev_irq(cnt_sev[i][j]);
			end

			// Either side registering anew restarts the stop hold and raises the acknowledge flag.
			assign any_rise  = |rise;
			assign stop_done = (scnt >= mon_stop[i]);

			// Stop timer restarts at every new registered violation.
			// A stop time of zero still holds the warning up to the next tick, never less.
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					hold  <= 1'h0;
					scnt  <= `LMEC_RST_VAL;
					unack <= 1'h0;
				end else begin
					if (any_rise) begin
						hold <= 1'h1;
						scnt <= `LMEC_RST_VAL;
					end else if (hold && tick) begin
						if (stop_done) begin
							hold <= 1'h0;
						end else begin
							scnt <= scnt + `LMEC_TW'(1);
						end
					end
					unack <= any_rise | (unack & ~lim_ack[i]);
				end
			end

			// The monitor stays active while a violation stands or its stop hold runs.
			assign lim_active        = hold | (|lvl);
			assign next_lim_warn[i]  = lim_active;
			assign next_lim_irq[i]   = lim_active & lmec_sev_irq(mon_sev[i]);
			assign next_lim_unack[i] = unack;
		end
	endgenerate

	// All outputs are registered once more so that every port leaves a flip-flop.
	// The price is one more cycle of latency on every output against the internal state.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			lim_warn  <= '0;
			lim_irq   <= '0;
			lim_unack <= '0;
			lim_viol  <= '0;
			cnt_value <= '0;
			cnt_warn  <= '0;
			cnt_irq   <= '0;
		end else begin
			lim_warn  <= next_lim_warn;
			lim_irq   <= next_lim_irq;
			lim_unack <= next_lim_unack;
			lim_viol  <= next_lim_viol;
			cnt_value <= next_cnt_value;
			cnt_warn  <= next_cnt_warn;
			cnt_irq   <= next_cnt_irq;
		end
	end

endmodule // lmec_top

// ==== verif/lmec_chk_asserts.sv ====
// Port-level assertions for the limit monitor and event counter block.
`timescale 1ns/100ps
`include "lmec_map.svh"

module lmec_chk (
	input  wire logic                                      clk,
	input  wire logic                                      nrst,
	input  wire logic [`LMEC_NMON-1:0]                     mon_enable,
	input  wire logic [`LMEC_NMON-1:0]                     lim_ack,
	input  wire logic [`LMEC_NMON-1:0][1:0]                cnt_clr,
	input  wire logic [`LMEC_NMON-1:0][1:0]                cnt_ack,
	input  wire logic [`LMEC_NMON-1:0]                     lim_warn,
	input  wire logic [`LMEC_NMON-1:0]                     lim_irq,
	input  wire logic [`LMEC_NMON-1:0]                     lim_unack,
	input  wire logic [`LMEC_NMON-1:0][1:0]                lim_viol,
	input  wire logic [`LMEC_NMON-1:0][1:0][`LMEC_CW-1:0]  cnt_value,
	input  wire logic [`LMEC_NMON-1:0][1:0]                cnt_warn,
	input  wire logic [`LMEC_NMON-1:0][1:0]                cnt_irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	irq_needs_warn_a: assert property ((lim_irq & ~lim_warn) == 3'h0)
		else $error("limit interrupt without warning");
	cnt_irq_gate_a: assert property ((cnt_irq & ~cnt_warn) == 6'h00)
		else $error("counter interrupt without warning");
	viol_shows_warn_a: assert property (|lim_viol[0] |-> lim_warn[0])
		else $error("registered violation without warning");
	disabled_clear_a: assert property ((!mon_enable[0])[*3] |-> lim_viol[0] == 2'h0)
		else $error("disabled monitor shows a violation");
	unack_sticky_a: assert property (lim_unack[0] && !lim_ack[0] && !$past(lim_ack[0]) |=> lim_unack[0])
		else $error("limit message cleared without acknowledge");
	cnt_warn_sticky_a: assert property (cnt_warn[0][0] && !cnt_ack[0][0] && !$past(cnt_ack[0][0]) |=> cnt_warn[0][0])
		else $error("counter warning cleared without acknowledge");
	clear_zeroes_a: assert property (cnt_clr[0][1] |-> ##2 cnt_value[0][1] == 16'h0000)
		else $error("counter not cleared");
	count_step_a: assert property (!$past(cnt_clr[0][0]) && !$past(cnt_clr[0][0], 2) |->
		cnt_value[0][0] == $past(cnt_value[0][0]) || cnt_value[0][0] == $past(cnt_value[0][0]) + 16'h0001)
		else $error("counter moved by more than one");
endmodule // lmec_chk

bind lmec_top lmec_chk u_chk (.clk, .nrst, .mon_enable, .lim_ack, .cnt_clr, .cnt_ack, .lim_warn, .lim_irq,
	.lim_unack, .lim_viol, .cnt_value, .cnt_warn, .cnt_irq);

// ==== verif/lmec_host.sv ====
// Behavioural configuration host issuing acknowledges and counter resets.
`timescale 1ns/100ps
`include "lmec_map.svh"

module lmec_host (
	input  wire logic                       clk,
	output logic [`LMEC_NMON-1:0]           lim_ack,
	output logic [`LMEC_NMON-1:0][1:0]      cnt_clr,
	output logic [`LMEC_NMON-1:0][1:0]      cnt_ack
);
	initial begin
		lim_ack = '0;
		cnt_clr = '0;
		cnt_ack = '0;
	end

	// Every command is a one-cycle pulse at one message; the host never clears collectively.
	task automatic ack_lim(input int i);
		lim_ack[i] = 1'b1;
		@(posedge clk);
		#1;
		lim_ack[i] = 1'b0;
	endtask

	task automatic ack_cnt(input int i, input int j);
		cnt_ack[i][j] = 1'b1;
		@(posedge clk);
		#1;
		cnt_ack[i][j] = 1'b0;
	endtask

	task automatic clr_cnt(input int i, input int j);
		cnt_clr[i][j] = 1'b1;
		@(posedge clk);
		#1;
		cnt_clr[i][j] = 1'b0;
	endtask
endmodule // lmec_host

// ==== verif/testbench.sv ====
// Self-checking testbench for the limit monitor and event counter block.
`timescale 1ns/100ps
`include "lmec_map.svh"

module testbench;
	logic                                      clk, nrst;
	logic [`LMEC_NVAR-1:0][`LMEC_VW-1:0]       var_value;
	logic [`LMEC_NVAR-1:0]                     var_active;
	logic [`LMEC_NMON-1:0]                     mon_enable, mon_sev, cnt_enable, lim_ack, lim_warn, lim_irq, lim_unack;
	logic [`LMEC_NMON-1:0][`LMEC_SELW-1:0]     mon_sel;
	logic [`LMEC_NMON-1:0][1:0]                mon_dir, cnt_sev, cnt_clr, cnt_ack, lim_viol, cnt_warn, cnt_irq;
	logic [`LMEC_NMON-1:0][`LMEC_VW-1:0]       mon_upper, mon_lower, mon_hyst;
	logic [`LMEC_NMON-1:0][`LMEC_TW-1:0]       mon_resp, mon_stop;
	logic [`LMEC_NMON-1:0][1:0][`LMEC_CW-1:0]  cnt_cmp, cnt_value;
	int                                        bad_count = 0;
	int                                        cmp_count = 0;

	// A short tick keeps response and stop times within a few dozen cycles.
	lmec_top #(.TICK_CYCLES(4)) uut (.clk, .nrst, .var_value, .var_active, .mon_enable, .mon_sel, .mon_sev,
		.mon_dir, .mon_upper, .mon_lower, .mon_hyst, .mon_resp, .mon_stop, .lim_ack, .cnt_enable, .cnt_sev,
		.cnt_cmp, .cnt_clr, .cnt_ack, .lim_warn, .lim_irq, .lim_unack, .lim_viol, .cnt_value, .cnt_warn, .cnt_irq);
	lmec_host uh (.clk, .lim_ack, .cnt_clr, .cnt_ack);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wait_viol(input int i, input int j, input logic v);
		for (int n = 0; n < 40 && lim_viol[i][j] !== v; n++)
			step(1);
		chk(lim_viol[i][j], v);
	endtask

	task automatic t_upper;
		var_value[0] = 16'h0065;
		wait_viol(0, 0, 1'b1);
		step(2);
		chk(lim_irq[0], 1'b1);
		chk(cnt_value[0][0], 16'h0001);
		chk(cnt_irq[0], 2'h1);
		var_value[0] = 16'h005B;
		step(10);
		chk(lim_viol[0], 2'h1);
		var_value[0] = 16'h0059;
		wait_viol(0, 0, 1'b0);
		chk(lim_warn[0], 1'b1);
		step(40);
		chk(lim_warn[0], 1'b0);
		chk(lim_unack[0], 1'b1);
		uh.ack_lim(0);
		step(2);
		chk(lim_unack[0], 1'b0);
		chk(cnt_warn[0], 2'h1);
		uh.ack_cnt(0, 0);
		step(2);
		chk(cnt_warn[0], 2'h0);
		$display("Test upper done");
	endtask

	task automatic t_resp;
		mon_resp[0] = 16'h0003;
		var_value[0] = 16'h0065;
		step(4);
		var_value[0] = 16'h0000;
		step(20);
		chk(lim_warn[0], 1'b0);
		var_value[0] = 16'h0065;
		step(6);
		chk(lim_viol[0], 2'h0);
		wait_viol(0, 0, 1'b1);
		step(2);
		chk(cnt_value[0][0], 16'h0002);
		chk(cnt_warn[0][0], 1'b0);
		var_value[0] = 16'h0000;
		mon_resp[0] = 16'h0000;
		wait_viol(0, 0, 1'b0);
		uh.clr_cnt(0, 0);
		step(2);
		chk(cnt_value[0][0], 16'h0000);
		$display("Test response done");
	endtask

	task automatic t_lower;
		mon_dir[0] = 2'h2;
		var_value[0] = 16'h0065;
		step(10);
		chk(lim_viol[0], 2'h0);
		var_value[0] = 16'hFF9B;
		wait_viol(0, 1, 1'b1);
		var_value[0] = 16'h0000;
		wait_viol(0, 1, 1'b0);
		step(2);
		chk(cnt_warn[0][1], 1'b0);
		var_value[0] = 16'hFF9B;
		wait_viol(0, 1, 1'b1);
		step(2);
		chk(cnt_value[0][1], 16'h0002);
		chk(cnt_warn[0], 2'h2);
		chk(cnt_irq[0], 2'h0);
		uh.clr_cnt(0, 1);
		step(2);
		chk(cnt_value[0][1], 16'h0000);
		chk(cnt_warn[0][1], 1'b1);
		$display("Test lower done");
	endtask

	task automatic t_select;
		var_active[0] = 1'b0;
		step(4);
		chk(lim_viol[0], 2'h0);
		var_active[0] = 1'b1;
		mon_enable[0] = 1'b0;
		step(4);
		chk(lim_viol[0], 2'h0);
		var_value[1] = 16'h0065;
		wait_viol(1, 0, 1'b1);
		chk(lim_irq[1], 1'b0);
		$display("Test select done");
	endtask

	initial begin
		nrst = 1'b0;
		var_value = '0;
		var_active = 4'hF;
		mon_enable = 3'h7;
		mon_sel = 6'h24;
		mon_sev = 3'h1;
		mon_dir = 6'h3F;
		mon_upper = {3{16'h0064}};
		mon_lower = {3{16'hFF9C}};
		mon_hyst = {3{16'h000A}};
		mon_resp = '0;
		mon_stop = {3{16'h0008}};
		cnt_enable = 3'h7;
		cnt_sev = 6'h01;
		cnt_cmp = '0;
		cnt_cmp[0][0] = 16'h0001;
		cnt_cmp[0][1] = 16'h0002;
		repeat (4) @(posedge clk);
		#1;
		nrst = 1'b1;
		step(1);
		chk(lim_warn, 3'h0);
		t_upper();
		t_resp();
		t_lower();
		t_select();
		tally_and_finish();
	end

	// The whole sequence takes well under a thousand cycles.
	initial begin
		#40000;
		bad_count++;
		tally_and_finish();
	end
endmodule // testbench
